// >>> core/vdt_timing.sv
// dot divider, character clock and horizontal counter pair with cell dot masking
module vdt_timing
	import vdt_pkg::*;
(
	// clock and reset; i_clock is the dot clock
	input wire logic i_clock,
	input wire logic i_rst_n,
	// cell pixel request
	input wire logic [6:0] i_glyph_row,
	input wire logic [3:0] i_scan_line,
	input wire logic i_descender,
	// dot and character timing
	output logic o_load_n,
	output logic o_char_clock_n,
	output logic o_char_clock,
	output logic o_char_tick,
	output logic [3:0] o_dot_count,
	// horizontal timing
	output logic [3:0] o_h_lo,
	output logic [3:0] o_h_hi,
	output logic o_h_preset,
	output vdt_horiz_t o_horiz,
	// serial video dot
	output logic o_video_dot
);
	logic [3:0] dot_q;
	logic [3:0] h_lo_q;
	logic [3:0] h_hi_q;
	logic [8:0] shift_q;
	logic load_n_q;
	logic cclk_n_q;
	logic dot_wrap;
	logic h_term;
	logic row_lit;
	logic [8:0] cell_bits;
	logic [6:0] line_chars_q;

	// true when a scan line lies in a glyph window
	function automatic logic in_win(input logic [3:0] ln, input logic [3:0] lo,
			input logic [3:0] hi);
		in_win = (ln >= lo) && (ln <= hi);
	endfunction

	// divide by nine: count 7..15 then reload; every dot edge is a step
	// reloading to seven keeps the end of a character on one compare, at fifteen
	assign dot_wrap = (dot_q == VDT_DOT_TOP);
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			dot_q <= VDT_DOT_PRESET;
		end else if (dot_wrap) begin
			dot_q <= VDT_DOT_PRESET;
		end else begin
			dot_q <= dot_q + 4'h1;
		end
	end

	// strobes registered so both rise on one dot edge
	// registering costs a dot of latency but keeps both edges free of decode glitches
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			load_n_q <= 1'b1;
			cclk_n_q <= 1'b1;
		end else begin
			// low for the dot where the count sits at fifteen
			load_n_q <= ~(dot_q == 4'he);
			// high on counts 7..11, low on 12..15: five high, four low
			cclk_n_q <= ~((dot_q >= 4'hb) && (dot_q != VDT_DOT_TOP));
		end
	end

	assign o_load_n = load_n_q;
	assign o_char_clock_n = cclk_n_q;
	assign o_char_clock = ~cclk_n_q;
	assign o_char_tick = dot_wrap;
	assign o_dot_count = dot_q;

	// terminal decode: high at nine, low at eight
	assign h_term = (h_hi_q == VDT_H_HI_TERM) && (h_lo_q == VDT_H_LO_TERM);

	// horizontal pair steps once per character, as the character clock would
	// a step enable on the dot clock avoids a second clock domain; the pair
	// moves on the dot edge where the true character clock falls
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			h_lo_q <= VDT_H_PRESET;
			h_hi_q <= VDT_H_PRESET;
		end else if (dot_wrap) begin
			if (h_term) begin
				h_lo_q <= VDT_H_PRESET;
				h_hi_q <= VDT_H_PRESET;
			end else begin
				h_lo_q <= h_lo_q + 4'h1;
				if (h_lo_q == 4'hf) begin
					h_hi_q <= h_hi_q + 4'h1;
				end
			end
		end
	end

	assign o_h_lo = h_lo_q;
	assign o_h_hi = h_hi_q;
	assign o_h_preset = h_term;
	assign o_horiz.line_advance = h_hi_q[VDT_LINE_BIT];
	assign o_horiz.horiz_active_window = h_hi_q[VDT_WINDOW_BIT];
	// column address: low counter and two low bits of the high counter, 64 cells
	assign o_horiz.column = {h_hi_q[1:0], h_lo_q};

	// pick whether this scan line may light for the glyph class
	// line one is tested first so no glyph class can close the gap between rows
	always_comb begin
		row_lit = 1'b0;
		if (i_scan_line == 4'h1) begin
			row_lit = 1'b0;
		end else if (i_descender) begin
			row_lit = in_win(i_scan_line, VDT_DSC_FIRST, VDT_DSC_LAST);
		end else begin
			row_lit = in_win(i_scan_line, VDT_STD_FIRST, VDT_STD_LAST);
		end
	end

	// seven glyph dots then two spacer dots, thirteen lines per cell
	assign cell_bits = row_lit ? {i_glyph_row, 2'b00} : 9'h000;

	// shift register loaded at the load strobe, msb out first
	// a glyph change between loads only shows from the next cell on
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			shift_q <= 9'h000;
		end else if (!load_n_q) begin
			shift_q <= cell_bits;
		end else begin
			shift_q <= {shift_q[7:0], 1'b0};
		end
	end

	assign o_video_dot = shift_q[8];

	// assertions

	// characters since the last preset; read only by the line length check below
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			line_chars_q <= 7'h00;
		end else if (dot_wrap) begin
			if (h_term) begin
				line_chars_q <= 7'h00;
			end else begin
				line_chars_q <= line_chars_q + 7'h01;
			end
		end
	end

	// divider at the top of its count, end of a character period
	sequence s_wrap;
		dot_q == VDT_DOT_TOP;
	endsequence

	// load strobe idle for eight dots and then low again
	sequence s_load_gap;
		load_n_q [*8] ##1 !load_n_q;
	endsequence

	// inverted character clock five dots high, then four low
	sequence s_cclk_period;
		cclk_n_q [*5] ##1 !cclk_n_q [*4];
	endsequence

	// last character step of the line, where the pair reloads
	sequence s_preset_step;
		dot_wrap && h_term;
	endsequence

	property p_div9;
		@(posedge i_clock) disable iff (!i_rst_n)
		s_wrap |=> (dot_q == VDT_DOT_PRESET) ##8 (dot_q == VDT_DOT_TOP);
	endproperty
	a_div9: assert property (p_div9) else $error("divider not nine");

	property p_load_one;
		@(posedge i_clock) disable iff (!i_rst_n)
		$fell(load_n_q) |=> s_load_gap;
	endproperty
	a_load_one: assert property (p_load_one) else $error("load strobe width");

	// the strobe may only be low on the last dot, when the shift register reloads
	property p_load_phase;
		@(posedge i_clock) disable iff (!i_rst_n)
		!load_n_q |-> (dot_q == VDT_DOT_TOP);
	endproperty
	a_load_phase: assert property (p_load_phase) else $error("load strobe off phase");

	property p_cclk_duty;
		@(posedge i_clock) disable iff (!i_rst_n)
		$rose(cclk_n_q) |-> s_cclk_period ##1 cclk_n_q;
	endproperty
	a_cclk_duty: assert property (p_cclk_duty) else $error("char clock duty");

	// the low half of the inverted character clock covers the last four dots only
	property p_cclk_phase;
		@(posedge i_clock) disable iff (!i_rst_n)
		!cclk_n_q |-> (dot_q >= VDT_CCLK_LOW_FROM);
	endproperty
	a_cclk_phase: assert property (p_cclk_phase) else $error("char clock off phase");

	property p_rise_together;
		@(posedge i_clock) disable iff (!i_rst_n)
		$rose(load_n_q) |-> $rose(cclk_n_q);
	endproperty
	a_rise_together: assert property (p_rise_together) else $error("edges apart");

	property p_true_clock;
		@(posedge i_clock) disable iff (!i_rst_n)
		$fell(o_char_clock) |-> $rose(load_n_q);
	endproperty
	a_true_clock: assert property (p_true_clock) else $error("true clock phase");

	property p_preset;
		@(posedge i_clock) disable iff (!i_rst_n)
		s_preset_step |=> (h_lo_q == VDT_H_PRESET) && (h_hi_q == VDT_H_PRESET);
	endproperty
	a_preset: assert property (p_preset) else $error("preset not three");

	// a full line is 102 character steps, counted apart from the pair itself
	property p_line_len;
		@(posedge i_clock) disable iff (!i_rst_n)
		s_preset_step |-> (line_chars_q == 7'(VDT_LINE_CHARS - 1));
	endproperty
	a_line_len: assert property (p_line_len) else $error("line length");

	// the pair only moves on a character step
	property p_hold;
		@(posedge i_clock) disable iff (!i_rst_n)
		!dot_wrap |=> $stable(h_lo_q) && $stable(h_hi_q);
	endproperty
	a_hold: assert property (p_hold) else $error("pair moved between characters");

	property p_carry;
		@(posedge i_clock) disable iff (!i_rst_n)
		(dot_wrap && h_lo_q == 4'hf) |=> (h_hi_q == $past(h_hi_q) + 4'h1);
	endproperty
	a_carry: assert property (p_carry) else $error("high counter carry");

	// after preset the low counter runs 13 characters before its first carry
	property p_first_pass;
		@(posedge i_clock) disable iff (!i_rst_n)
		s_preset_step |=> (h_lo_q == VDT_H_PRESET) ##116
			(dot_wrap && (h_lo_q == 4'hf) && (h_hi_q == VDT_H_PRESET));
	endproperty
	a_first_pass: assert property (p_first_pass) else $error("first pass length");

	// window spans high counts four to seven, line advance eight and up
	property p_window;
		@(posedge i_clock) disable iff (!i_rst_n)
		(o_horiz.horiz_active_window == ((h_hi_q >= 4'h4) && (h_hi_q <= 4'h7))) &&
			(o_horiz.line_advance == (h_hi_q >= 4'h8));
	endproperty
	a_window: assert property (p_window) else $error("window bits");

	property p_spacer;
		@(posedge i_clock) disable iff (!i_rst_n)
		$rose(load_n_q) |-> ##7 !o_video_dot ##1 !o_video_dot;
	endproperty
	a_spacer: assert property (p_spacer) else $error("spacer dot lit");

	property p_dark_first;
		@(posedge i_clock) disable iff (!i_rst_n)
		(!load_n_q && i_scan_line == 4'h1) |=> shift_q == 9'h000;
	endproperty
	a_dark_first: assert property (p_dark_first) else $error("first line lit");

	// an ordinary glyph below its window loads a dark cell
	property p_std_window;
		@(posedge i_clock) disable iff (!i_rst_n)
		(!load_n_q && !i_descender && (i_scan_line > VDT_STD_LAST)) |=> shift_q == 9'h000;
	endproperty
	a_std_window: assert property (p_std_window) else $error("glyph below window");

	// a descending glyph above its window loads a dark cell
	property p_desc_window;
		@(posedge i_clock) disable iff (!i_rst_n)
		(!load_n_q && i_descender && (i_scan_line < VDT_DSC_FIRST)) |=> shift_q == 9'h000;
	endproperty
	a_desc_window: assert property (p_desc_window) else $error("descender above");

	// reset leaves divider, strobes and the pair at their preset values
	property p_reset_preset;
		@(posedge i_clock)
		!i_rst_n |=> (dot_q == VDT_DOT_PRESET) && (h_lo_q == VDT_H_PRESET) &&
			(h_hi_q == VDT_H_PRESET) && load_n_q && cclk_n_q;
	endproperty
	a_reset_preset: assert property (p_reset_preset) else $error("reset state");
endmodule

// >>> pkg/vdt_pkg.sv
// package of constants and carrier types for the dot and character timing block
package vdt_pkg;
	// page and cell geometry
	localparam int VDT_COLS = 64;
	localparam int VDT_ROWS = 16;
	localparam int VDT_PAGE_CHARS = 1024;
	localparam int VDT_CELL_W = 9;
	localparam int VDT_CELL_H = 13;
	localparam int VDT_GLYPH_W = 7;
	// glyph scan-line windows, numbered 1..13
	localparam logic [3:0] VDT_STD_FIRST = 4'h2;
	localparam logic [3:0] VDT_STD_LAST = 4'ha;
	localparam logic [3:0] VDT_DSC_FIRST = 4'h5;
	localparam logic [3:0] VDT_DSC_LAST = 4'hd;
	// dot divider
	localparam logic [3:0] VDT_DOT_PRESET = 4'h7;
	localparam logic [3:0] VDT_DOT_TOP = 4'hf;
	localparam logic [3:0] VDT_CCLK_LOW_FROM = 4'hc;
	// horizontal counter pair
	localparam logic [3:0] VDT_H_PRESET = 4'h3;
	localparam logic [3:0] VDT_H_HI_TERM = 4'h9;
	localparam logic [3:0] VDT_H_LO_TERM = 4'h8;
	localparam int VDT_LINE_CHARS = 102;
	localparam int VDT_LINE_BIT = 3;
	localparam int VDT_WINDOW_BIT = 2;
	// timing
	localparam real VDT_DOT_NS = 69.8;
	localparam real VDT_CHAR_NS = 628.0;
	localparam real VDT_LINE_US = 64.0;
	localparam real VDT_CLK_NS = 25.0;
	localparam int VDT_CLK_PER_DOT = 1;
	// horizontal state carried out of the block
	typedef struct packed {
		logic line_advance;
		logic horiz_active_window;
		logic [5:0] column;
	} vdt_horiz_t;
endpackage

// >>> verification/vdt_monitor.sv
// video monitor model that integrates the serial dot stream
module vdt_monitor (
	// clock and video in
	input wire logic i_clock,
	input wire logic i_dot,
	// count control
	input wire logic i_clear,
	// lit dots seen since clear
	output int o_lit
);
	timeunit 1ns;
	timeprecision 1ps;
	// a tube only sums light, so cell phase does not matter to it
	always @(posedge i_clock) begin
		if (i_clear) begin
			o_lit <= 0;
		end else if (i_dot === 1'b1) begin
			o_lit <= o_lit + 1;
		end
	end
endmodule

// >>> verification/video_dot_character_timing_tb_top.sv
// self-checking bench for the dot and character timing block
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin num_errors++; \
	$display("ERROR %s expected %0h seen %0h", nm, ex, got); end end
module video_dot_character_timing_tb_top;
	import vdt_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_clock = 1'b0;
	logic i_rst_n = 1'b0;
	logic [6:0] glyph = 7'h00;
	logic [3:0] scan = 4'h1;
	logic desc = 1'b0;
	logic clear = 1'b1;
	logic load_n, cclk_n, cclk, tick, preset, dot;
	logic [3:0] dot_cnt, h_lo, h_hi;
	vdt_horiz_t horiz;
	int lit, cnt;
	int num_errors = 0;
	int checks_done = 0;
	int cycles = 0;
	vdt_timing u_dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_glyph_row(glyph),
		.i_scan_line(scan), .i_descender(desc), .o_load_n(load_n), .o_char_clock_n(cclk_n),
		.o_char_clock(cclk), .o_char_tick(tick), .o_dot_count(dot_cnt), .o_h_lo(h_lo),
		.o_h_hi(h_hi), .o_h_preset(preset), .o_horiz(horiz), .o_video_dot(dot));
	vdt_monitor u_monitor (.i_clock(i_clock), .i_dot(dot), .i_clear(clear), .o_lit(lit));
	// 40 MHz, each rising edge stands for one dot
	always #12.5 i_clock = ~i_clock;
	task automatic end_of_test();
		if (num_errors == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// cut a hang well beyond the few lines the run needs
	always @(posedge i_clock) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			end_of_test();
		end
	end
	// one character period from count seven
	task automatic check_divider();
		cnt = 0;
		@(negedge i_clock);
		while (dot_cnt !== VDT_DOT_PRESET && cnt < 20) begin
			@(negedge i_clock);
			cnt++;
		end
		for (int i = 0; i < 9; i++) begin
			`CHK("dot_count", 4'h7 + i[3:0], dot_cnt)
			`CHK("load_n", (i == 8) ? 1'b0 : 1'b1, load_n)
			`CHK("char_clock_n", (i >= 5) ? 1'b0 : 1'b1, cclk_n)
			`CHK("char_clock", (i >= 5) ? 1'b1 : 1'b0, cclk)
			`CHK("char_tick", (i == 8) ? 1'b1 : 1'b0, tick)
			@(negedge i_clock);
		end
		`CHK("rise_together", 2'b11, {load_n, cclk_n})
	endtask
	// one full line measured from terminal decode to terminal decode
	task automatic check_line();
		cnt = 0;
		while (preset !== 1'b1 && cnt < 2000) begin
			@(negedge i_clock);
			cnt++;
		end
		`CHK("term_count", 8'h98, {h_hi, h_lo})
		`CHK("advance_window", 2'b10, {horiz.line_advance, horiz.horiz_active_window})
		`CHK("column", 6'h18, horiz.column)
		cnt = 0;
		while (preset === 1'b1 && cnt < 2000) begin
			@(negedge i_clock);
			cnt++;
		end
		`CHK("preset_dots", 9, cnt)
		while (preset !== 1'b1 && cnt < 2000) begin
			@(negedge i_clock);
			cnt++;
		end
		`CHK("line_dots", VDT_LINE_CHARS * VDT_CELL_W, cnt)
	endtask
	// hold a glyph line steady and count light over three cells
	task automatic run_glyph(input logic [6:0] g, input logic [3:0] s, input logic d,
		input int per_cell);
		@(posedge i_clock);
		glyph <= g;
		scan <= s;
		desc <= d;
		repeat (18) @(posedge i_clock);
		clear <= 1'b1;
		@(posedge i_clock);
		clear <= 1'b0;
		repeat (27) @(posedge i_clock);
		@(negedge i_clock);
		`CHK("lit_dots", 3 * per_cell, lit)
	endtask
	// hold reset for five edges, check the preset state, then release
	task automatic check_reset();
		@(posedge i_clock);
		i_rst_n <= 1'b0;
		repeat (4) @(posedge i_clock);
		@(negedge i_clock);
		`CHK("reset_state", 12'h733, {dot_cnt, h_hi, h_lo})
		`CHK("reset_strobes", 3'b110, {load_n, cclk_n, dot})
		@(posedge i_clock);
		i_rst_n <= 1'b1;
	endtask
	initial begin
		check_reset();
		check_divider();
		check_line();
		run_glyph(7'h7f, 4'h1, 1'b0, 0);
		run_glyph(7'h7f, 4'h2, 1'b0, 7);
		run_glyph(7'h7f, 4'ha, 1'b0, 7);
		run_glyph(7'h7f, 4'hb, 1'b0, 0);
		run_glyph(7'h7f, 4'h4, 1'b1, 0);
		run_glyph(7'h7f, 4'hd, 1'b1, 7);
		run_glyph(7'h55, 4'h5, 1'b0, 4);
		check_reset();
		check_divider();
		end_of_test();
	end
endmodule
